// File: rtl/twf_consts.svh
// Offsets, field widths and length limits of the frame-field sequencer
`ifndef TWF_CONSTS_SVH
`define TWF_CONSTS_SVH

`define TWF_OFS_CFG   3'h0
`define TWF_OFS_MCMD  3'h1
`define TWF_OFS_TXD   3'h2
`define TWF_OFS_RXD   3'h3
`define TWF_OFS_STAT  3'h4
`define TWF_OFS_NONE  3'h7

`define TWF_SADR_W    4'hC
`define TWF_CTRL_W    4'h4
`define TWF_BYTE_W    4'h8
`define TWF_ADR_ALL   12'hFFF
`define TWF_MAX_M0    8'h10
`define TWF_MAX_M1    8'h20
`define TWF_MAX_M2    8'h80
`define TWF_LEN_256   9'h100
`define TWF_SLV_LEN   8'h01

`endif

// File: rtl/twf_pkg.sv
// Types of the frame-field sequencer
package twf_pkg;

    typedef enum logic [2:0] {FLD_IDLE, FLD_SADR, FLD_CTRL, FLD_LEN, FLD_DATA} twf_field_e;

    typedef struct packed {
        twf_field_e  fld;
        logic [3:0]  cnt;
        logic [11:0] sh;
        logic        par;
        logic        keep;
        logic        master;
        logic        multi;
        logic        mpar_ok;
        logic [11:0] peer;
        logic [3:0]  ctrl;
        logic [8:0]  left;
        logic [7:0]  nfr;
        logic        tx_bit;
        logic [11:0] own;
        logic [1:0]  mode;
        logic        tx_en;
        logic [11:0] sadr;
        logic [3:0]  mctrl;
        logic [7:0]  mlen;
        logic        mnorm;
        logic        go;
        logic [7:0]  txd;
        logic        tx_full;
        logic [7:0]  rxd;
        logic        rx_full;
        logic        locked;
        logic [11:0] lock_adr;
        logic        done;
        logic        abort;
        logic        dph_wr;
        logic [2:0]  dph_idx;
        logic [31:0] rdata;
    } twf_state_s;

endpackage : twf_pkg

// File: rtl/twf_frame.sv
// Frame-field sequencer: slave address tail, control, length and data fields
`timescale 1ns/1ps
`default_nettype none
`include "twf_consts.svh"

module twf_frame #(
    parameter logic [1:0] MODE_SUP = 2'b10
) (
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        hsel_i,
    input  wire logic [7:0]  haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        frame_start_i,
    input  wire logic        is_master_i,
    input  wire logic        multi_bit_i,
    input  wire logic [11:0] maddr_i,
    input  wire logic        maddr_par_ok_i,
    input  wire logic        slot_i,
    input  wire logic        rx_bit_i,
    input  wire logic        timing_err_i,
    output logic             tx_bit_o,
    output logic             lead_o,
    output logic             master_req_o,
    output logic             multi_bit_o,
    output logic      [11:0] own_addr_o
);
    import twf_pkg::*;

    twf_state_s  s;
    twf_state_s  next_s;
    logic [3:0]  w;
    logic        xmit;
    logic        par_ok;
    logic        accept;
    logic        proceed;
    logic        good;
    logic        last;
    logic        nx_xmit;
    logic        take;
    logic        ev;
    logic [11:0] ld;
    logic [8:0]  left_n;
    logic [7:0]  nfr_n;

    // ==========================================================
    // Helpers
    function automatic logic [3:0] fld_width(input twf_field_e f);
        case (f)
            FLD_SADR: fld_width = `TWF_SADR_W;
            FLD_CTRL: fld_width = `TWF_CTRL_W;
            default:  fld_width = `TWF_BYTE_W;
        endcase
    endfunction : fld_width

    function automatic logic [7:0] max_bytes(input logic [1:0] m);
        case (m)
            2'h0:    max_bytes = `TWF_MAX_M0;
            2'h1:    max_bytes = `TWF_MAX_M1;
            default: max_bytes = `TWF_MAX_M2;
        endcase
    endfunction : max_bytes

    function automatic logic is_lock_cmd(input logic [3:0] c);
        is_lock_cmd = (c == 4'h3) || (c == 4'hA) || (c == 4'hB);
    endfunction : is_lock_cmd

    // Control code check on the slave side
    function automatic logic ctrl_ok(input logic [3:0] c, input twf_state_s st);
        logic undef;
        logic guarded;
        undef   = (c == 4'h1) || (c == 4'h2) || (c == 4'h8) || (c == 4'h9) || (c == 4'hC) || (c == 4'hD);
        guarded = is_lock_cmd(c) || (c == 4'h6) || (c == 4'h7) || (c == 4'hE) || (c == 4'hF);
        ctrl_ok = !undef
                  && !(c[3] && st.rx_full)
                  && !(((c == 4'h3) || (c == 4'h7)) && !st.tx_full)
                  && !(st.locked && (st.peer != st.lock_adr) && guarded)
                  && !((c == 4'h4) && !st.locked)
                  && !(st.multi && !c[3]);
    endfunction : ctrl_ok

    // Byte a slave returns for a read code
    function automatic logic [7:0] slave_byte(input logic [3:0] c, input twf_state_s st);
        case (c)
            4'h0, 4'h6: slave_byte = {MODE_SUP, 1'b0, st.tx_en, 1'b0, st.locked, st.rx_full, st.tx_full};
            4'h4:       slave_byte = st.lock_adr[7:0];
            4'h5:       slave_byte = {4'h0, st.lock_adr[11:8]};
            default:    slave_byte = st.txd;
        endcase
    endfunction : slave_byte

    // ==========================================================
    // Next state
    always_comb begin
        next_s = s;
        w      = fld_width(s.fld);
        xmit   = ((s.fld == FLD_SADR) || (s.fld == FLD_CTRL)) ? s.master : (s.master == s.ctrl[3]);
        par_ok = ~(s.par ^ rx_bit_i);
        case (s.fld)
            FLD_SADR: accept = par_ok && s.mpar_ok
                               && (s.multi ? ((s.sh == `TWF_ADR_ALL)
                                              || (s.sh[11:8] == s.own[11:8]))
                                           : (s.sh == s.own));
            FLD_CTRL: accept = par_ok && ctrl_ok(s.sh[3:0], s);
            FLD_LEN:  accept = par_ok;
            FLD_DATA: accept = par_ok && !s.rx_full;
            default:  accept = 1'b0;
        endcase
        proceed = xmit ? (s.multi || !rx_bit_i) : s.keep;
        good    = proceed;
        left_n  = good ? s.left - 9'h001 : s.left;
        nfr_n   = s.nfr + 8'h01;
        last    = (left_n == 9'h000) || (nfr_n == max_bytes(s.mode));
        nx_xmit = 1'b0;
        ld      = 12'h000;
        take    = hsel_i && htrans_i[1] && hready_i;
        ev      = slot_i && !timing_err_i && !frame_start_i;

        // Address phase: reads and their side effects
        if (take) begin
            next_s.dph_wr  = hwrite_i;
            next_s.dph_idx = (haddr_i[7:5] == 3'h0) ? haddr_i[4:2] : `TWF_OFS_NONE;
            next_s.rdata   = 32'h0000_0000;
            if (!hwrite_i) begin
                case ((haddr_i[7:5] == 3'h0) ? haddr_i[4:2] : `TWF_OFS_NONE)
                    `TWF_OFS_CFG:  next_s.rdata = {17'h0_0000, s.tx_en, s.mode, s.own};
                    `TWF_OFS_MCMD: next_s.rdata = {6'h00, s.go, s.mnorm, s.mlen, s.mctrl, s.sadr};
                    `TWF_OFS_TXD:  next_s.rdata = {24'h00_0000, s.txd};
                    `TWF_OFS_RXD: begin
                        next_s.rdata   = {24'h00_0000, s.rxd};
                        next_s.rx_full = 1'b0;
                    end
                    `TWF_OFS_STAT: begin
                        next_s.rdata = {13'h0000, s.go, s.left, s.abort, s.done, s.rx_full,
                                        s.tx_full, s.locked, s.master, s.fld};
                        next_s.done  = 1'b0;
                        next_s.abort = 1'b0;
                    end
                    default:       next_s.rdata = 32'h0000_0000;
                endcase
            end
        end else begin
            next_s.dph_wr  = 1'b0;
            next_s.dph_idx = `TWF_OFS_NONE;
        end

        // Field sequencing; hardware sets below win over read clears above
        if (frame_start_i) begin
            next_s.fld     = FLD_SADR;
            next_s.cnt     = 4'h0;
            next_s.par     = 1'b0;
            next_s.keep    = 1'b0;
            next_s.master  = is_master_i;
            next_s.multi   = !multi_bit_i;
            next_s.mpar_ok = maddr_par_ok_i;
            next_s.peer    = maddr_i;
            next_s.sh      = is_master_i ? s.sadr : 12'h000;
            next_s.tx_bit  = is_master_i ? s.sadr[11] : 1'b1;
            if (is_master_i) begin
                next_s.go = 1'b0;
            end
        end else if (timing_err_i && (s.fld != FLD_IDLE)) begin
            next_s.fld    = FLD_IDLE;
            next_s.tx_bit = 1'b1;
            next_s.abort  = 1'b1;
        end else if (slot_i && (s.fld != FLD_IDLE)) begin
            next_s.tx_bit = 1'b1;
            next_s.cnt    = s.cnt + 4'h1;
            if (s.cnt < w) begin
                next_s.sh  = {s.sh[10:0], rx_bit_i};
                next_s.par = s.par ^ rx_bit_i;
                if (xmit) begin
                    next_s.tx_bit = (s.cnt == w - 4'h1) ? (s.par ^ rx_bit_i) : s.sh[10];
                end
            end else if (s.cnt == w) begin
                next_s.keep = xmit || accept;
                if (!xmit && !s.multi && accept) begin
                    next_s.tx_bit = 1'b0;
                end
                if ((s.fld == FLD_DATA) && !xmit && accept) begin
                    next_s.rxd     = s.sh[7:0];
                    next_s.rx_full = 1'b1;
                end
            end else begin
                next_s.cnt = 4'h0;
                next_s.par = 1'b0;
                if (s.fld == FLD_SADR) begin
                    if (!proceed) begin
                        next_s.fld   = FLD_IDLE;
                        next_s.abort = 1'b1;
                    end else begin
                        next_s.fld = FLD_CTRL;
                        nx_xmit    = s.master;
                        ld         = {s.mctrl, 8'h00};
                    end
                end else if (s.fld == FLD_CTRL) begin
                    next_s.ctrl = s.sh[3:0];
                    if (!proceed) begin
                        next_s.fld   = FLD_IDLE;
                        next_s.abort = 1'b1;
                    end else begin
                        next_s.fld = FLD_LEN;
                        nx_xmit    = s.master == s.sh[3];
                        ld         = {s.master ? s.mlen : `TWF_SLV_LEN, 4'h0};
                    end
                end else if (s.fld == FLD_LEN) begin
                    if (!proceed) begin
                        next_s.fld   = FLD_IDLE;
                        next_s.abort = 1'b1;
                    end else begin
                        next_s.fld  = FLD_DATA;
                        next_s.left = (s.sh[7:0] == 8'h00) ? `TWF_LEN_256 : {1'b0, s.sh[7:0]};
                        next_s.nfr  = 8'h00;
                        nx_xmit     = xmit;
                        ld          = {s.master ? s.txd : slave_byte(s.ctrl, s), 4'h0};
                    end
                end else begin
                    next_s.left = left_n;
                    next_s.nfr  = nfr_n;
                    if (good && xmit && (s.master || (s.ctrl == 4'h3) || (s.ctrl == 4'h7))) begin
                        next_s.tx_full = 1'b0;
                    end
                    if (last) begin
                        next_s.fld  = FLD_IDLE;
                        next_s.done = next_s.done || (left_n == 9'h000);
                        if (s.master && (left_n != 9'h000)) begin
                            next_s.mlen = left_n[7:0];
                            next_s.go   = 1'b1;
                        end
                        if (!s.master && !s.multi) begin
                            if ((left_n == 9'h000) && (is_lock_cmd(s.ctrl) || (s.ctrl == 4'h6))) begin
                                next_s.locked = 1'b0;
                            end else if (is_lock_cmd(s.ctrl)) begin
                                next_s.locked   = 1'b1;
                                next_s.lock_adr = s.peer;
                            end
                        end
                    end else begin
                        nx_xmit = xmit;
                        ld      = {s.master ? s.txd : slave_byte(s.ctrl, s), 4'h0};
                    end
                end
                if (nx_xmit) begin
                    next_s.sh     = ld;
                    next_s.tx_bit = ld[11];
                end else begin
                    next_s.sh = 12'h000;
                end
            end
        end

        // Data phase: writes; software sets win over hardware clears
        if (s.dph_wr) begin
            case (s.dph_idx)
                `TWF_OFS_CFG: begin
                    next_s.own   = hwdata_i[11:0];
                    next_s.mode  = hwdata_i[13:12];
                    next_s.tx_en = hwdata_i[14];
                end
                `TWF_OFS_MCMD: begin
                    next_s.sadr  = hwdata_i[11:0];
                    next_s.mctrl = hwdata_i[15:12];
                    next_s.mlen  = hwdata_i[23:16];
                    next_s.mnorm = hwdata_i[24];
                    next_s.go    = hwdata_i[25];
                end
                `TWF_OFS_TXD: begin
                    next_s.txd     = hwdata_i[7:0];
                    next_s.tx_full = 1'b1;
                end
                default: next_s.go = next_s.go;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            s        <= '0;
            s.tx_bit <= 1'b1;
            s.mnorm  <= 1'b1;
            s.dph_idx <= `TWF_OFS_NONE;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign hrdata_o     = s.rdata;
    assign hreadyout_o  = 1'b1;
    assign hresp_o      = 1'b0;
    assign tx_bit_o     = s.tx_bit;
    assign lead_o       = s.master && (s.fld != FLD_IDLE);
    assign master_req_o = s.go;
    assign multi_bit_o  = s.mnorm;
    assign own_addr_o   = s.own;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    sadr_nak_a : assert property (
        ev && !s.master && !s.multi && (s.fld == FLD_SADR) && (s.cnt == 4'hC) && !accept |=> tx_bit_o && !s.keep)
        else $error("slave acked an address it must refuse");
    nak_standby_a : assert property (
        ev && s.master && !s.multi && (s.fld == FLD_SADR) && (s.cnt == 4'hD) && rx_bit_i |=> s.fld == FLD_IDLE)
        else $error("master kept the frame after address nak");
    bcast_match_a : assert property (
        ev && !s.master && s.multi && (s.fld == FLD_SADR) && (s.cnt == 4'hC) && par_ok && s.mpar_ok
        && (s.sh == 12'hFFF) |=> s.keep)
        else $error("broadcast not taken");
    ctrl_reject_a : assert property (
        ev && !s.master && (s.fld == FLD_CTRL) && (s.cnt == 4'h4) && !accept |=> tx_bit_o && !s.keep)
        else $error("control acked though refused");
    len_count_a : assert property (
        ev && (s.fld == FLD_LEN) && (s.cnt == 4'h9) && proceed && (s.sh[7:0] == 8'h00) |=> s.left == 9'h100)
        else $error("zero length is not 256 bytes");
    len_odd_a : assert property (
        ev && !s.master && s.ctrl[3] && (s.fld == FLD_LEN) && (s.cnt == 4'h8) && !par_ok
        |=> tx_bit_o ##0 !s.keep)
        else $error("odd length parity acked");
    data_full_a : assert property (
        ev && !s.master && s.ctrl[3] && (s.fld == FLD_DATA) && (s.cnt == 4'h8) && s.rx_full
        |=> tx_bit_o && $stable(s.rxd))
        else $error("byte taken into a full buffer");
    resend_byte_a : assert property (
        ev && s.master && s.ctrl[3] && !s.multi && (s.fld == FLD_DATA) && (s.cnt == 4'h9) && rx_bit_i && !last
        |=> (s.fld == FLD_DATA) && (s.sh[11:4] == $past(s.txd)) && (s.left == $past(s.left)))
        else $error("byte not resent after nak");
    parity_out_a : assert property (
        (s.fld != FLD_IDLE) && xmit && (s.cnt == w) |-> tx_bit_o == s.par)
        else $error("parity slot carries wrong value");
    multi_quiet_a : assert property (
        s.multi && !s.master && (s.fld != FLD_IDLE) |-> tx_bit_o)
        else $error("slave drove the bus in a multiaddress frame");
    multi_sel_a : assert property (
        frame_start_i && !multi_bit_i |=> s.multi)
        else $error("header bit zero did not select multiaddress");
    sadr_ack_a : assert property (
        ev && !s.master && !s.multi && (s.fld == FLD_SADR) && (s.cnt == 4'hC) && accept |=> !tx_bit_o)
        else $error("own address not acked");
    rx_take_a : assert property (
        ev && !xmit && (s.fld == FLD_DATA) && (s.cnt == 4'h8) && accept
        |=> s.rx_full && (s.rxd == $past(s.sh[7:0])))
        else $error("accepted byte not stored");
    ctrl_full_a : assert property (
        ev && !s.master && (s.fld == FLD_CTRL) && (s.cnt == 4'h4) && s.sh[3] && s.rx_full |=> !s.keep)
        else $error("write accepted into a full buffer");
    terr_stop_a : assert property (
        timing_err_i && !frame_start_i && (s.fld != FLD_IDLE) |=> (s.fld == FLD_IDLE) && s.abort)
        else $error("timing error did not end the frame");
    read_ack_a : assert property (
        ev && s.master && !xmit && !s.multi && (s.fld == FLD_DATA) && (s.cnt == 4'h8) && accept |=> !tx_bit_o)
        else $error("reading master did not ack");
    byte_reread_a : assert property (
        ev && s.master && !xmit && (s.fld == FLD_DATA) && (s.cnt == 4'h9) && !s.keep && !last
        |=> (s.fld == FLD_DATA) && (s.left == $past(s.left)))
        else $error("refused byte not read again");
    ack_release_a : assert property (
        ev && xmit && (s.fld != FLD_IDLE) && (s.cnt == w) |=> tx_bit_o)
        else $error("sender drove its own ack slot");

endmodule : twf_frame

`default_nettype wire

// File: bench/twf_far_unit.sv
// Far-side bus unit: replays a bit pattern slot by slot, wired AND with the block
`timescale 1ns/1ps
`default_nettype none

module twf_far_unit (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        start_i,
    input  wire logic [6:0]  nbits_i,
    input  wire logic [63:0] pat_i,
    input  wire logic        tx_bit_i,
    output logic             slot_o,
    output logic             rx_bit_o,
    output logic             busy_o,
    output logic      [63:0] seen_o
);
    logic [63:0] pat;
    logic [6:0]  left;
    logic [1:0]  gap;
    logic        bus_bit;

    // =========================================
    // Slot replay
    assign bus_bit = pat[6'(left - 7'd1)] & tx_bit_i;
    always_ff @(posedge clk_i) begin
        slot_o <= 1'b0;
        rx_bit_o <= 1'b1;
        if (srst_i) begin
            busy_o <= 1'b0;
            seen_o <= 64'h0000_0000_0000_0000;
            pat <= 64'h0000_0000_0000_0000;
            left <= 7'h00;
            gap <= 2'h0;
        end else if (start_i) begin
            pat <= pat_i;
            left <= nbits_i;
            gap <= 2'h0;
            busy_o <= (nbits_i != 7'h00);
            seen_o <= 64'h0000_0000_0000_0000;
        end else if (busy_o) begin
            gap <= gap + 2'h1;
            // Slots only inside frames, four cycles apart
            if (gap == 2'h3) begin
                slot_o <= 1'b1;
                rx_bit_o <= bus_bit;
                seen_o <= {seen_o[62:0], bus_bit};
                left <= left - 7'd1;
                busy_o <= (left != 7'd1);
            end
        end
    end
endmodule : twf_far_unit
`default_nettype wire

// File: bench/test_twf_frame.sv
// Testbench of the frame-field sequencer against a replaying far-side unit
`timescale 1ns/1ps
`default_nettype none

module test_twf_frame;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hrdy;
    logic        hresp;
    logic        fstart = 1'b0;
    logic        is_mst = 1'b0;
    logic        mbit = 1'b1;
    logic        mok = 1'b1;
    logic        slot;
    logic        rx_bit;
    logic        tx_bit;
    logic        lead;
    logic        mreq;
    logic        mbit_o;
    logic [11:0] own;
    logic        fst = 1'b0;
    logic        terr = 1'b0;
    logic [6:0]  nbits = 7'h00;
    logic [63:0] pat = 64'h0000_0000_0000_0000;
    logic        busy;
    logic [63:0] seen;
    logic [63:0] drv;
    logic [63:0] expv;
    logic [6:0]  nb;
    logic [31:0] d;
    int          num_errors = 0;
    int          total_checks = 0;
    logic [4:0]  nak [10] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h07, 5'h08, 5'h09, 5'h0C, 5'h0D, 5'h1F};
    logic [7:0]  zadr [4] = '{8'h00, 8'h0C, 8'h10, 8'h1C};

    always #10 clk = ~clk;

    twf_frame i_dut (
        .core_clk_i(clk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hrdy), .hwdata_i(hwdata), .hrdata_o(hrdata),
        .hreadyout_o(hrdy), .hresp_o(hresp), .frame_start_i(fstart), .is_master_i(is_mst),
        .multi_bit_i(mbit), .maddr_i(12'h0AB), .maddr_par_ok_i(mok), .slot_i(slot), .rx_bit_i(rx_bit),
        .timing_err_i(terr), .tx_bit_o(tx_bit), .lead_o(lead), .master_req_o(mreq),
        .multi_bit_o(mbit_o), .own_addr_o(own)
    );
    twf_far_unit i_far (
        .clk_i(clk), .srst_i(srst), .start_i(fst), .nbits_i(nbits), .pat_i(pat), .tx_bit_i(tx_bit),
        .slot_o(slot), .rx_bit_o(rx_bit), .busy_o(busy), .seen_o(seen)
    );

    // =========================================
    // Checking and closing
    task automatic check(input logic [63:0] got, input logic [63:0] want);
        total_checks++;
        if (got !== want) begin
            num_errors++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // =========================================
    // Register bus master
    task automatic rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hrdy !== 1'b1) begin
            n++;
            if (n > 50) begin
                num_errors++;
                print_verdict();
            end
            @(posedge clk);
        end
    endtask : rdy

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy();
        d = hrdata;
        @(negedge clk);
    endtask : xfer

    // =========================================
    // Frame building: partner drive and expected bus bits
    task automatic put(input logic pd, input logic ev);
        drv = {drv[62:0], pd};
        expv = {expv[62:0], ev};
        nb = nb + 7'd1;
    endtask : put

    task automatic add(input logic [11:0] v, input int w, input logic pd, input logic fl,
                       input logic pa, input logic ea);
        logic p;
        p = fl;
        for (int i = w - 1; i >= 0; i--) begin
            p = p ^ v[i];
            put(pd ? v[i] : 1'b1, v[i]);
        end
        put(pd ? p : 1'b1, p);
        put(pa, ea);
    endtask : add

    task automatic clr();
        drv = 64'h0000_0000_0000_0000;
        expv = 64'h0000_0000_0000_0000;
        nb = 7'h00;
    endtask : clr

    task automatic run(input logic mst, input logic mb);
        int n;
        n = 0;
        @(posedge clk);
        fstart <= 1'b1;
        is_mst <= mst;
        mbit <= mb;
        fst <= 1'b1;
        nbits <= nb;
        pat <= drv;
        @(posedge clk);
        fstart <= 1'b0;
        fst <= 1'b0;
        repeat (2) @(posedge clk);
        check(64'(lead), 64'(mst));
        while (busy === 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 1000) begin
                num_errors++;
                print_verdict();
            end
        end
        repeat (4) @(posedge clk);
        check(seen, expv);
    endtask : run

    // =========================================
    // Scenarios
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check(64'({tx_bit, lead, mreq, mbit_o, own, hresp}), 64'h0000_0000_0001_2000);
        xfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
        foreach (zadr[k]) begin
            xfer(1'b0, zadr[k], 32'h0000_0000);
            check(64'(d), 64'h0000_0000_0000_0000);
        end
        xfer(1'b1, 8'h00, 32'h0000_4123);
        check(64'(own), 64'h0000_0000_0000_0123);
        // Slave write with one parity retry, then full buffer refusal
        clr();
        add(12'h123, 12, 1, 0, 1, 0);
        add(12'h00F, 4, 1, 0, 1, 0);
        add(12'h001, 8, 1, 0, 1, 0);
        add(12'h0A5, 8, 1, 1, 1, 1);
        add(12'h0A5, 8, 1, 0, 1, 0);
        run(1'b0, 1'b1);
        xfer(1'b0, 8'h10, 32'h0000_0000);
        check(64'(d & 32'h0000_0047), 64'h0000_0000_0000_0040);
        clr();
        add(12'h123, 12, 1, 0, 1, 0);
        add(12'h00F, 4, 1, 0, 1, 1);
        run(1'b0, 1'b1);
        xfer(1'b0, 8'h0C, 32'h0000_0000);
        check(64'(d & 32'h0000_00FF), 64'h0000_0000_0000_00A5);
        clr();
        add(12'h124, 12, 1, 0, 1, 1);
        run(1'b0, 1'b1);
        mok <= 1'b0;
        clr();
        add(12'h123, 12, 1, 0, 1, 1);
        run(1'b0, 1'b1);
        mok <= 1'b1;
        foreach (nak[k]) begin
            clr();
            add(12'h123, 12, 1, 0, 1, 0);
            add(12'(nak[k][3:0]), 4, 1, nak[k][4], 1, 1);
            run(1'b0, 1'b1);
        end
        // Master write, data refused once then resent
        xfer(1'b1, 8'h08, 32'h0000_005A);
        xfer(1'b1, 8'h04, 32'h0301_F456);
        check(64'({mreq, mbit_o}), 64'h0000_0000_0000_0003);
        clr();
        add(12'h456, 12, 0, 0, 0, 0);
        add(12'h00F, 4, 0, 0, 0, 0);
        add(12'h001, 8, 0, 0, 0, 0);
        add(12'h05A, 8, 0, 0, 1, 1);
        add(12'h05A, 8, 0, 0, 0, 0);
        run(1'b1, 1'b1);
        xfer(1'b0, 8'h10, 32'h0000_0000);
        check(64'(d & 32'h0000_0187), 64'h0000_0000_0000_0180);
        // Broadcast master write, refusals ignored
        xfer(1'b1, 8'h08, 32'h0000_0077);
        xfer(1'b1, 8'h04, 32'h0201_FFFF);
        check(64'(mbit_o), 64'h0000_0000_0000_0000);
        clr();
        add(12'hFFF, 12, 0, 0, 1, 1);
        add(12'h00F, 4, 0, 0, 1, 1);
        add(12'h001, 8, 0, 0, 1, 1);
        add(12'h077, 8, 0, 0, 1, 1);
        run(1'b1, 1'b0);
        xfer(1'b0, 8'h10, 32'h0000_0000);
        check(64'(d & 32'h0000_0187), 64'h0000_0000_0000_0080);
        // Master finds no slave
        xfer(1'b1, 8'h04, 32'h0301_F456);
        clr();
        add(12'h456, 12, 0, 0, 1, 1);
        run(1'b1, 1'b1);
        xfer(1'b0, 8'h10, 32'h0000_0000);
        check(64'(d & 32'h0000_0107), 64'h0000_0000_0000_0100);
        check(64'(lead), 64'h0000_0000_0000_0000);
        // Master read, bad parity reread, then slave takes a broadcast write
        xfer(1'b1, 8'h04, 32'h0301_7456);
        clr();
        add(12'h456, 12, 0, 0, 0, 0);
        add(12'h007, 4, 0, 0, 0, 0);
        add(12'h001, 8, 1, 0, 1, 0);
        add(12'h03C, 8, 1, 1, 1, 1);
        add(12'h03C, 8, 1, 0, 1, 0);
        run(1'b1, 1'b1);
        xfer(1'b0, 8'h0C, 32'h0000_0000);
        check(64'(d & 32'h0000_00FF), 64'h0000_0000_0000_003C);
        clr();
        add(12'hFFF, 12, 1, 0, 1, 1);
        add(12'h00F, 4, 1, 0, 1, 1);
        add(12'h001, 8, 1, 0, 1, 1);
        add(12'h096, 8, 1, 0, 1, 1);
        run(1'b0, 1'b0);
        xfer(1'b0, 8'h0C, 32'h0000_0000);
        check(64'(d & 32'h0000_00FF), 64'h0000_0000_0000_0096);
        // Zero length, full buffer refusal, cut by a timing error
        clr();
        add(12'h123, 12, 1, 0, 1, 0);
        add(12'h00F, 4, 1, 0, 1, 0);
        add(12'h000, 8, 1, 0, 1, 0);
        add(12'h011, 8, 1, 0, 1, 0);
        add(12'h022, 8, 1, 0, 1, 1);
        run(1'b0, 1'b1);
        xfer(1'b0, 8'h10, 32'h0000_0000);
        check(64'(d & 32'h0003_FE4F), 64'h0000_0000_0001_FE44);
        @(posedge clk);
        terr <= 1'b1;
        @(posedge clk);
        terr <= 1'b0;
        xfer(1'b0, 8'h10, 32'h0000_0000);
        check(64'(d & 32'h0000_0107), 64'h0000_0000_0000_0100);
        print_verdict();
    end
endmodule : test_twf_frame
`default_nettype wire
